/* File: lcm_cfg.svh */
// constants for the control/status map and power data register
// ----------------------------------------------------------------------
// Behaviour
// - power data read-only, chosen by select field
// - power data fixed constants, 0.01 W units
// - selects 0-3: scale 2, 60 then 42
// - selects 4-7: scale 2, 58 then 40
// - select 8 zero scale 2; 9-15 zero, scale 0
// - offset 00H low word shows unit status
// - 00H high word takes commands; acks go to bits 15:8
// - 04H general pointer given to units
// - 08H port write: reset, self test, dump
// - 0CH: eeprom high word, flash low word
// - flash writes blocked unless enabled
// - 10H carries phy management read/write requests
// - 18H: early rx, flow control, wake byte
// - wake byte shows wake-up interrupt occurred
// - 1CH status: duplex, speed, link
// - select field is bits 12:9 of pm control
// - scale field 14:13 reads 10b or 00b
// ----------------------------------------------------------------------
`ifndef LCM_CFG_SVH
`define LCM_CFG_SVH
// register byte offsets
`define LCM_OFF_UNIT 6'h00
`define LCM_OFF_GPTR 6'h04
`define LCM_OFF_PORT 6'h08
`define LCM_OFF_NVM 6'h0c
`define LCM_OFF_PHY 6'h10
`define LCM_OFF_RXCNT 6'h14
`define LCM_OFF_FLOW 6'h18
`define LCM_OFF_GEN 6'h1c
// power management control/status field positions
`define LCM_SEL_LSB 9
`define LCM_SEL_MSB 12
`define LCM_SCALE_LSB 13
`define LCM_SCALE_MSB 14
// fixed power figures, hundredths of a watt
`define LCM_PWR_CONS_D0 8'h3c
`define LCM_PWR_CONS_DX 8'h2a
`define LCM_PWR_DISS_D0 8'h3a
`define LCM_PWR_DISS_DX 8'h28
`define LCM_PWR_ZERO 8'h00
`define LCM_SCALE_VALID 2'h2
`define LCM_SCALE_RSVD 2'h0
// field positions inside the map
`define LCM_FLASH_WE_BIT 0
`define LCM_PORT_FN_MSB 3
`define LCM_ACK_LSB 8
`define LCM_ACK_MSB 15
`define LCM_GC_DEEP_PD_BIT 0
`define LCM_GC_CLKRUN_DIS_BIT 1
// reset values
`define LCM_RST_W16 16'h0000
`define LCM_RST_W32 32'h00000000
`define LCM_RST_B8 8'h00
`endif

/* File: lcm_csr_map.sv */
// control/status register map of the network controller
`timescale 1ns/1ns
`include "lcm_cfg.svh"
module lcm_csr_map (
  input wire logic CLK_I, // bus clock, 25 MHz
  input wire logic SYS_RST_I, // synchronous reset, high
  input lcm_pkg::lcm_req_t REQ_I, // host access
  output logic [31:0] RDATA_O, // read data, registered
  output logic RVALID_O, // read data valid pulse
  input wire logic [15:0] POWER_MGMT_CTRL_STATUS_WDATA_I, // pm write data
  input wire logic POWER_MGMT_CTRL_STATUS_WR_I, // pm write strobe
  output logic [15:0] POWER_MGMT_CTRL_STATUS_O, // pm word readback
  output logic [7:0] PWR_DATA_O, // power data register, registered
  input wire logic [15:0] UNIT_STATUS_I, // unit status from units
  input wire logic [7:0] ACK_STATUS_SET_I, // event bits to set
  output logic [7:0] ACK_O, // interrupt acknowledge pulse
  output logic [15:0] CMD_O, // command word
  output logic CMD_WR_O, // command written pulse
  output logic [31:0] GPTR_O, // general pointer
  output logic [31:0] PORT_O, // port word
  output logic PORT_WR_O, // port written pulse
  output logic [15:0] EEPROM_O, // eeprom control
  output logic EEPROM_WR_O, // eeprom written pulse
  input wire logic [15:0] EEPROM_I, // eeprom status bits
  output logic [15:0] FLASH_O, // flash control
  input wire logic FLASH_WR_REQ_I, // flash write cycle requested
  output logic FLASH_WR_OK_O, // flash write cycle allowed
  output logic [31:0] PHY_O, // phy management request
  output logic PHY_WR_O, // phy request pulse
  input wire logic [31:0] PHY_I, // phy management result
  input wire logic RX_DMA_I, // receive dma add pulse
  input wire logic [15:0] RX_BYTES_I, // bytes moved
  output logic [7:0] EARLY_RX_O, // early receive setting
  output logic [15:0] FLOW_O, // flow control word
  input wire logic WAKE_EVT_I, // wake-up event pulse
  output logic [7:0] WAKE_O, // wake indication byte
  output logic DEEP_PD_O, // deep power-down request
  output logic CLKRUN_DIS_O, // clock-run disabled
  input lcm_pkg::lcm_link_t LINK_I // link status
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] ack_status_q; // sticky event bits, upper status byte
  logic [7:0] ack_status_d; // next event bits
  logic [15:0] cmd_q; // command word
  logic [31:0] gptr_q; // general pointer
  logic [31:0] port_q; // last port word
  logic [15:0] eeprom_q; // eeprom control
  logic [15:0] flash_q; // flash control
  logic [31:0] phy_q; // phy management request
  logic [7:0] early_q; // early receive setting
  logic [15:0] flow_q; // flow control
  logic [7:0] wake_q; // wake indication
  logic [7:0] wake_d; // next wake indication
  logic [7:0] gctl_q; // general control
  logic [15:0] power_mgmt_ctrl_status_q; // pm word, select field kept
  logic [31:0] rdata_q; // read data
  logic rvalid_q; // read valid
  logic [7:0] ack_q; // ack pulse
  logic cmd_wr_q; // command pulse
  logic port_wr_q; // port pulse
  logic eeprom_wr_q; // eeprom pulse
  logic phy_wr_q; // phy pulse
  logic [7:0] pwr_q; // registered power data
  logic [31:0] rx_count; // received byte count
  lcm_pkg::lcm_pwr_t pwr; // lookup result
  logic [3:0] dsel; // data select field
  logic [31:0] rd_mux; // read selection
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // byte-enable merge, used for every writable word
  function automatic logic [31:0] lcm_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
  // address match for one word, used for every offset
  function automatic logic lcm_hit(input logic [5:0] a,
      input logic [5:0] off);
    return a[5:2] == off[5:2];
  endfunction
  wire wr = REQ_I.wr; // write strobe
  wire [5:0] a = REQ_I.addr; // byte offset
  wire [3:0] be = REQ_I.be; // byte enables
  wire [31:0] wd = REQ_I.wdata; // write data
  wire hit_unit = lcm_hit(a, `LCM_OFF_UNIT); // 00H
  wire hit_gptr = lcm_hit(a, `LCM_OFF_GPTR); // 04H
  wire hit_port = lcm_hit(a, `LCM_OFF_PORT); // 08H
  wire hit_nvm = lcm_hit(a, `LCM_OFF_NVM); // 0CH
  wire hit_phy = lcm_hit(a, `LCM_OFF_PHY); // 10H
  wire hit_rx = lcm_hit(a, `LCM_OFF_RXCNT); // 14H
  wire hit_flow = lcm_hit(a, `LCM_OFF_FLOW); // 18H
  wire hit_gen = lcm_hit(a, `LCM_OFF_GEN); // 1CH
  wire [31:0] m_unit = lcm_merge({cmd_q, 16'h0000}, wd, be);
  wire [31:0] m_gptr = lcm_merge(gptr_q, wd, be);
  wire [31:0] m_port = lcm_merge(`LCM_RST_W32, wd, be);
  wire [31:0] m_nvm = lcm_merge({eeprom_q, flash_q}, wd, be);
  wire [31:0] m_phy = lcm_merge(phy_q, wd, be);
  wire [31:0] m_flow = lcm_merge({wake_q, flow_q, early_q}, wd, be);
  wire [31:0] m_gen = lcm_merge({24'h000000, gctl_q}, wd, be);
  // acks are write-one bits in the upper status byte
  wire [7:0] ack_wr = (wr && hit_unit && be[1]) ? wd[15:8] : 8'h00;
  // wake byte is write-one-to-clear from the top byte of 18H
  wire [7:0] wake_clr = (wr && hit_flow && be[3]) ? wd[31:24] : 8'h00;
  // ------------------------------------------------------------
  // sticky bits
  // ------------------------------------------------------------
  // set wins over clear so no event is lost in the ack cycle
  assign ack_status_d = ACK_STATUS_SET_I | (ack_status_q & ~ack_wr);
  assign wake_d = {7'h00, WAKE_EVT_I} | (wake_q & ~wake_clr);
  // ------------------------------------------------------------
  // power data
  // ------------------------------------------------------------
  assign dsel = power_mgmt_ctrl_status_q[`LCM_SEL_MSB:`LCM_SEL_LSB];
  lcm_power_data u_pwr (
    .sel_i(dsel),
    .pwr_o(pwr)
  );
  // ------------------------------------------------------------
  // receive byte count
  // ------------------------------------------------------------
  // writes to 14H are ignored; a software reset clears it
  wire port_reset = wr && hit_port && be[0] &&
      (wd[`LCM_PORT_FN_MSB:0] == 4'(lcm_pkg::LCM_PORT_SW_RESET));
  lcm_rx_counter u_rx (
    .CLK_I(CLK_I),
    .rst_i(SYS_RST_I),
    .clr_i(port_reset),
    .add_i(RX_DMA_I),
    .bytes_i(RX_BYTES_I),
    .count_o(rx_count)
  );
  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // port is write only, reserved offsets and 20H up read zero
  assign rd_mux = hit_unit ? {cmd_q, ack_status_q,
                              UNIT_STATUS_I[7:2], 2'b00} :
                  hit_gptr ? gptr_q :
                  hit_nvm ? {eeprom_q | EEPROM_I, flash_q} :
                  hit_phy ? PHY_I :
                  hit_rx ? rx_count :
                  hit_flow ? {wake_q, flow_q, early_q} :
                  hit_gen ? {16'h0000, 5'h00, LINK_I, gctl_q} :
                  `LCM_RST_W32;
  // ------------------------------------------------------------
  // registers written by the host
  // ------------------------------------------------------------
  // port reset clears these registers like a pin reset; sticky bits and pm word keep theirs, port word takes the write
  wire clr_all = SYS_RST_I || port_reset;
  always_ff @(posedge CLK_I) begin
    if (clr_all) begin
      cmd_q <= `LCM_RST_W16;
      gptr_q <= `LCM_RST_W32;
      eeprom_q <= `LCM_RST_W16;
      flash_q <= `LCM_RST_W16;
      phy_q <= `LCM_RST_W32;
      early_q <= `LCM_RST_B8;
      flow_q <= `LCM_RST_W16;
      gctl_q <= `LCM_RST_B8;
    end else if (wr) begin
      if (hit_unit) begin
        cmd_q <= m_unit[31:16];
      end
      if (hit_gptr) begin
        gptr_q <= m_gptr;
      end
      if (hit_nvm) begin
        eeprom_q <= m_nvm[31:16];
        flash_q <= m_nvm[15:0];
      end
      if (hit_phy) begin
        phy_q <= m_phy;
      end
      if (hit_flow) begin
        early_q <= m_flow[7:0];
        flow_q <= m_flow[23:8];
      end
      if (hit_gen) begin
        gctl_q <= m_gen[7:0];
      end
    end
  end
  // ------------------------------------------------------------
  // sticky and pm state
  // ------------------------------------------------------------
  // pm control word: only the select field is kept here
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ack_status_q <= `LCM_RST_B8;
      wake_q <= `LCM_RST_B8;
      power_mgmt_ctrl_status_q <= `LCM_RST_W16;
    end else begin
      ack_status_q <= ack_status_d;
      wake_q <= wake_d;
      // select lands at 12:9; other bits are stored as zero, scale 14:13 reads from the lookup
      if (POWER_MGMT_CTRL_STATUS_WR_I) begin
        power_mgmt_ctrl_status_q <= {3'h0,
            POWER_MGMT_CTRL_STATUS_WDATA_I[`LCM_SEL_MSB:`LCM_SEL_LSB],
            9'h000};
      end
    end
  end
  // ------------------------------------------------------------
  // strobes, read data, power data
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rdata_q <= `LCM_RST_W32;
      rvalid_q <= 1'b0;
      ack_q <= `LCM_RST_B8;
      cmd_wr_q <= 1'b0;
      port_wr_q <= 1'b0;
      port_q <= `LCM_RST_W32;
      eeprom_wr_q <= 1'b0;
      phy_wr_q <= 1'b0;
      pwr_q <= `LCM_RST_B8;
    end else begin
      rdata_q <= REQ_I.rd ? rd_mux : rdata_q;
      rvalid_q <= REQ_I.rd;
      ack_q <= ack_wr & ack_status_q;
      cmd_wr_q <= wr && hit_unit && (be[3] || be[2]);
      port_wr_q <= wr && hit_port;
      port_q <= (wr && hit_port) ? m_port : port_q;
      eeprom_wr_q <= wr && hit_nvm && (be[3] || be[2]);
      phy_wr_q <= wr && hit_phy;
      pwr_q <= pwr.data;
    end
  end
  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign RDATA_O = rdata_q;
  assign RVALID_O = rvalid_q;
  assign POWER_MGMT_CTRL_STATUS_O = {1'b0, pwr.scale,
      power_mgmt_ctrl_status_q[12:0]};
  assign PWR_DATA_O = pwr_q;
  assign ACK_O = ack_q;
  assign CMD_O = cmd_q;
  assign CMD_WR_O = cmd_wr_q;
  assign GPTR_O = gptr_q;
  assign PORT_O = port_q;
  assign PORT_WR_O = port_wr_q;
  assign EEPROM_O = eeprom_q;
  assign EEPROM_WR_O = eeprom_wr_q;
  assign FLASH_O = flash_q;
  // flash write cycles pass only with the enable bit set
  assign FLASH_WR_OK_O = FLASH_WR_REQ_I &&
      flash_q[`LCM_FLASH_WE_BIT];
  assign PHY_O = phy_q;
  assign PHY_WR_O = phy_wr_q;
  assign EARLY_RX_O = early_q;
  assign FLOW_O = flow_q;
  assign WAKE_O = wake_q;
  assign DEEP_PD_O = gctl_q[`LCM_GC_DEEP_PD_BIT];
  assign CLKRUN_DIS_O = gctl_q[`LCM_GC_CLKRUN_DIS_BIT];
endmodule

/* File: lcm_csr_map_monitor.sv */
// concurrent checks on the ports of the control/status map
`timescale 1ns/1ns
module lcm_csr_map_monitor (
  input wire logic CLK_I, // bus clock
  input wire logic SYS_RST_I, // sync reset, high
  input lcm_pkg::lcm_req_t REQ_I, // host access
  input wire logic [31:0] RDATA_O, // read data
  input wire logic RVALID_O, // read valid
  input wire logic [15:0] POWER_MGMT_CTRL_STATUS_O, // pm readback
  input wire logic [7:0] PWR_DATA_O, // power data
  input wire logic CMD_WR_O, // command pulse
  input wire logic [31:0] GPTR_O, // general pointer
  input wire logic PORT_WR_O, // port pulse
  input wire logic [15:0] FLASH_O, // flash control
  input wire logic FLASH_WR_REQ_I, // flash request
  input wire logic FLASH_WR_OK_O, // flash allowed
  input wire logic WAKE_EVT_I, // wake event
  input wire logic [7:0] WAKE_O // wake byte
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // expected figure, hundredths of a watt
  function automatic logic [7:0] pwr(input logic [3:0] s);
    return s == 4'h0 ? 8'h3c : s < 4'h4 ? 8'h2a : s == 4'h4 ? 8'h3a :
      s < 4'h8 ? 8'h28 : 8'h00;
  endfunction
  wire [3:0] sel = POWER_MGMT_CTRL_STATUS_O[12:9]; // select ordinal
  wire wr_port = REQ_I.wr && REQ_I.addr[5:2] == 4'h2 && REQ_I.be[0];
  // software reset is function code zero
  sequence port_reset_s;
    wr_port && REQ_I.wdata[3:0] == 4'h0;
  endsequence
  sequence cleared_s;
    GPTR_O == 32'h0 && PORT_WR_O;
  endsequence
  status_read_a: assert property (
    REQ_I.rd && REQ_I.addr[5:2] == 4'h0 |=> RVALID_O && RDATA_O[1:0] == 2'h0)
    else $error("status read wrong");
  // power data lags the select register one cycle
  power_value_a: assert property (
    !$past(SYS_RST_I) |-> PWR_DATA_O == pwr($past(sel)))
    else $error("power data wrong");
  data_scale_a: assert property (
    POWER_MGMT_CTRL_STATUS_O[14:13] == (sel <= 4'h8 ? 2'h2 : 2'h0))
    else $error("scale wrong");
  flash_gate_a: assert property (
    FLASH_WR_OK_O == (FLASH_WR_REQ_I && FLASH_O[0]))
    else $error("flash gate wrong");
  reserved_zero_a: assert property (
    REQ_I.rd && REQ_I.addr[5] |=> RDATA_O == 32'h0)
    else $error("reserved read not zero");
  port_pulse_a: assert property (
    wr_port |=> PORT_WR_O) else $error("port pulse missing");
  port_reset_a: assert property (
    port_reset_s |=> cleared_s) else $error("software reset missed");
  cmd_pulse_a: assert property (
    REQ_I.wr && REQ_I.addr[5:2] == 4'h0 && REQ_I.be[2] |=> CMD_WR_O)
    else $error("command pulse missing");
  wake_set_a: assert property (
    WAKE_EVT_I |=> WAKE_O[0]) else $error("wake bit not set");
endmodule

/* File: lcm_host.sv */
// host cpu model issuing accesses to the map
`timescale 1ns/1ns
module lcm_host (
  input wire logic clk_i, // bus clock
  input wire logic [31:0] rdata_i, // read data
  input wire logic rvalid_i, // read valid
  output lcm_pkg::lcm_req_t req_o // access
);
  // released lines show the inverse, so stale data never looks valid
  initial req_o = '0;
  // one write, held over exactly one taking edge
  task automatic wr(input logic [5:0] a, input logic [3:0] b,
                    input logic [31:0] w);
    @(posedge clk_i);
    req_o <= '{1'b0, 1'b1, a, b, w};
    @(posedge clk_i);
    req_o <= '{1'b0, 1'b0, ~a, ~b, ~w};
    #1;
  endtask
  // one read; answer sampled just after the taking edge, while it stands
  task automatic rd(input logic [5:0] a, output logic [31:0] d,
                    output logic v);
    @(posedge clk_i);
    req_o <= '{1'b1, 1'b0, a, 4'hf, 32'h0};
    @(posedge clk_i);
    req_o <= '{1'b0, 1'b0, ~a, 4'h0, 32'hffff_ffff};
    #1;
    v = rvalid_i;
    d = rdata_i;
  endtask
endmodule

/* File: lcm_pkg.sv */
// types shared by the control/status map files
package lcm_pkg;
  // port function codes written to the low nibble of the port register
  typedef enum logic [3:0] {
    LCM_PORT_SW_RESET = 4'h0,
    LCM_PORT_SELF_TEST = 4'h1,
    LCM_PORT_SEL_RESET = 4'h2,
    LCM_PORT_DUMP = 4'h3
  } lcm_port_fn_t;
  // one host access to the map
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } lcm_req_t;
  // what the power data logic reports
  typedef struct packed {
    logic [1:0] scale;
    logic [7:0] data;
  } lcm_pwr_t;
  // link state shown in general status
  typedef struct packed {
    logic full_duplex;
    logic speed_100;
    logic link_up;
  } lcm_link_t;
endpackage

/* File: lcm_power_data.sv */
// fixed power data lookup behind the power management capability
`timescale 1ns/1ns
`include "lcm_cfg.svh"
module lcm_power_data (
  input wire logic [3:0] sel_i, // data select field
  output lcm_pkg::lcm_pwr_t pwr_o // scale and data
);
  // ------------------------------------------------------------
  // lookup table
  // ------------------------------------------------------------
  // hard coded: nothing is measured, so no clock is needed
  function automatic lcm_pkg::lcm_pwr_t lcm_lookup(input logic [3:0] s);
    lcm_pkg::lcm_pwr_t r;
    r.scale = `LCM_SCALE_VALID;
    case (s)
      4'h0: r.data = `LCM_PWR_CONS_D0;
      4'h1, 4'h2, 4'h3: r.data = `LCM_PWR_CONS_DX;
      4'h4: r.data = `LCM_PWR_DISS_D0;
      4'h5, 4'h6, 4'h7: r.data = `LCM_PWR_DISS_DX;
      4'h8: r.data = `LCM_PWR_ZERO;
      default: begin
        r.data = `LCM_PWR_ZERO;
        r.scale = `LCM_SCALE_RSVD;
      end
    endcase
    return r;
  endfunction
  assign pwr_o = lcm_lookup(sel_i);
endmodule

/* File: lcm_rx_counter.sv */
// receive dma byte counter
`timescale 1ns/1ns
`include "lcm_cfg.svh"
module lcm_rx_counter (
  input wire logic CLK_I, // bus clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic clr_i, // clear pulse
  input wire logic add_i, // add pulse
  input wire logic [15:0] bytes_i, // bytes moved this pulse
  output logic [31:0] count_o // running byte count
);
  logic [31:0] count_q; // accumulated count
  logic [31:0] count_d; // next count
  // ------------------------------------------------------------
  // accumulate
  // ------------------------------------------------------------
  // clear drops the old count but keeps the add, so a transfer in the clearing cycle survives
  assign count_d = add_i ? (clr_i ? 32'(bytes_i) : count_q + 32'(bytes_i))
                         : (clr_i ? `LCM_RST_W32 : count_q);
  always_ff @(posedge CLK_I) begin
    if (rst_i) begin
      count_q <= `LCM_RST_W32;
    end else begin
      count_q <= count_d;
    end
  end
  assign count_o = count_q;
endmodule

/* File: test_lcm_csr_map.sv */
// self-checking bench for the control/status map
`timescale 1ns/1ns
module test_lcm_csr_map;
  logic clk = 1'b0, rst = 1'b1, pm_wr = 1'b0, fwr = 1'b0, rxd = 1'b0;
  logic wake = 1'b0, v, rvalid, cmd_wr, port_wr, eewr, fok, phywr;
  logic dpd, crd;
  logic [15:0] pm_wd = 16'h0, ust = 16'h0, eei = 16'h0, rxb = 16'h0;
  logic [15:0] pm_word, cmd, eeo, flash, flow;
  logic [7:0] aset = 8'h0, pwr, ack, early, wake_o;
  logic [31:0] phy_i = 32'h0, d, rdata, gptr, port, phyo;
  lcm_pkg::lcm_link_t link = '0;
  lcm_pkg::lcm_req_t req;
  int n_fail = 0, compares = 0, cyc = 0;
  always #20 clk = ~clk; // 25 MHz
  lcm_host host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid),
    .req_o(req));
  lcm_csr_map dut (.CLK_I(clk), .SYS_RST_I(rst), .REQ_I(req),
    .RDATA_O(rdata), .RVALID_O(rvalid),
    .POWER_MGMT_CTRL_STATUS_WDATA_I(pm_wd),
    .POWER_MGMT_CTRL_STATUS_WR_I(pm_wr),
    .POWER_MGMT_CTRL_STATUS_O(pm_word), .PWR_DATA_O(pwr),
    .UNIT_STATUS_I(ust), .ACK_STATUS_SET_I(aset), .ACK_O(ack),
    .CMD_O(cmd), .CMD_WR_O(cmd_wr), .GPTR_O(gptr), .PORT_O(port),
    .PORT_WR_O(port_wr), .EEPROM_O(eeo), .EEPROM_WR_O(eewr),
    .EEPROM_I(eei), .FLASH_O(flash), .FLASH_WR_REQ_I(fwr),
    .FLASH_WR_OK_O(fok), .PHY_O(phyo), .PHY_WR_O(phywr), .PHY_I(phy_i),
    .RX_DMA_I(rxd), .RX_BYTES_I(rxb), .EARLY_RX_O(early), .FLOW_O(flow),
    .WAKE_EVT_I(wake), .WAKE_O(wake_o), .DEEP_PD_O(dpd),
    .CLKRUN_DIS_O(crd), .LINK_I(link));
  // ----------------------------------------------------------------
  // shared checks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    host.rd(a, d, v);
    chk(v, 1'b1);
    chk(d, e);
  endtask
  task automatic report_and_stop();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hang guard, far above the roughly 150 cycles used
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // every select ordinal, stray bits set to prove only 12:9 kept
  task automatic t_power();
    logic [7:0] e;
    for (int s = 0; s < 16; s++) begin
      e = s == 0 ? 8'h3c : s < 4 ? 8'h2a : s == 4 ? 8'h3a :
        s < 8 ? 8'h28 : 8'h00;
      @(posedge clk) pm_wd <= {3'h7, 4'(s), 9'h1ff};
      pm_wr <= 1'b1;
      @(posedge clk) pm_wr <= 1'b0;
      @(posedge clk) #1;
      chk(pm_word, {1'b0, (s <= 8 ? 2'h2 : 2'h0), 4'(s),
          9'h000});
      chk(pwr, e);
    end
  endtask
  task automatic t_map();
    host.wr(6'h04, 4'hf, 32'h1357_9bdf);
    host.wr(6'h04, 4'h1, 32'hffff_ff22);
    rdc(6'h04, 32'h1357_9b22);
    host.wr(6'h0c, 4'hf, 32'h5a5a_a5a5);
    chk(eewr, 1'b1);
    @(posedge clk) eei <= 16'h8000;
    rdc(6'h0c, 32'hda5a_a5a5);
    chk({eeo, flash}, 32'h5a5a_a5a5);
    host.wr(6'h18, 4'h7, 32'hffc3_3c96);
    chk({flow, early}, 32'h00c3_3c96);
    host.wr(6'h10, 4'hf, 32'h2468_ace0);
    chk(phywr, 1'b1);
    chk(phyo, 32'h2468_ace0);
    @(posedge clk) phy_i <= 32'h0f0f_1234;
    rdc(6'h10, 32'h0f0f_1234);
    host.wr(6'h1c, 4'h1, 32'h0000_0003);
    chk({dpd, crd}, 2'h3);
    @(posedge clk) link <= '{1'b1, 1'b0, 1'b1};
    rdc(6'h1c, 32'h0000_0503);
    for (int a = 8; a < 16; a++) begin
      host.wr(6'(a * 4), 4'hf, 32'hffff_ffff);
      rdc(6'(a * 4), 32'h0);
    end
    rdc(6'h08, 32'h0);
    rdc(6'h04, 32'h1357_9b22);
  endtask
  // sticky events, acknowledge, then a command
  task automatic t_unit();
    @(posedge clk) ust <= 16'h00ff;
    aset <= 8'h81;
    @(posedge clk) aset <= 8'h00;
    host.rd(6'h00, d, v);
    chk(d[15:0], 16'h81fc);
    host.wr(6'h00, 4'h2, 32'h0000_0100);
    chk(ack, 8'h01);
    host.rd(6'h00, d, v);
    chk(d[15:0], 16'h80fc);
    host.wr(6'h00, 4'h4, 32'h0010_0000);
    chk({cmd_wr, cmd}, 17'h1_0010);
  endtask
  // two dma adds back to back; a host write must not disturb them
  task automatic t_rx();
    @(posedge clk) rxd <= 1'b1;
    rxb <= 16'h0100;
    @(posedge clk) rxb <= 16'h0081;
    @(posedge clk) rxd <= 1'b0;
    host.wr(6'h14, 4'hf, 32'h0);
    rdc(6'h14, 32'h0000_0181);
  endtask
  task automatic t_flash_wake();
    @(posedge clk) fwr <= 1'b1;
    @(posedge clk) #1;
    chk(fok, 1'b1);
    host.wr(6'h0c, 4'h1, 32'h0);
    chk(eewr, 1'b0);
    chk(fok, 1'b0);
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    rdc(6'h18, 32'h01c3_3c96);
    host.wr(6'h18, 4'h8, 32'h0100_0000);
    chk(wake_o, 8'h0);
  endtask
  // other functions only pulse; software reset clears gptr and the rx count
  task automatic t_port();
    for (int f = 1; f < 4; f++) begin
      host.wr(6'h08, 4'hf, 32'(f));
      chk(port_wr, 1'b1);
      chk(port, 32'(f));
    end
    chk(gptr, 32'h1357_9b22);
    host.wr(6'h08, 4'h1, 32'h0);
    chk(gptr, 32'h0);
    rdc(6'h14, 32'h0);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_power();
    t_map();
    t_unit();
    t_rx();
    t_flash_wake();
    t_port();
    report_and_stop();
  end
endmodule
bind lcm_csr_map lcm_csr_map_monitor mon (.CLK_I(CLK_I),
  .SYS_RST_I(SYS_RST_I), .REQ_I(REQ_I), .RDATA_O(RDATA_O),
  .RVALID_O(RVALID_O),
  .POWER_MGMT_CTRL_STATUS_O(POWER_MGMT_CTRL_STATUS_O),
  .PWR_DATA_O(PWR_DATA_O),
  .CMD_WR_O(CMD_WR_O), .GPTR_O(GPTR_O), .PORT_WR_O(PORT_WR_O),
  .FLASH_O(FLASH_O), .FLASH_WR_REQ_I(FLASH_WR_REQ_I),
  .FLASH_WR_OK_O(FLASH_WR_OK_O), .WAKE_EVT_I(WAKE_EVT_I), .WAKE_O(WAKE_O));
